/* src/uhl_params.svh */
// Register offsets, field positions and reset values of the list control block
`ifndef UHL_PARAMS_SVH
`define UHL_PARAMS_SVH
`define UHL_ADDR_W 12
`define UHL_CTRL_OFS 12'h004
`define UHL_CMD_OFS 12'h008
`define UHL_RATIO_LSB 0
`define UHL_PLE_BIT 2
`define UHL_IE_BIT 3
`define UHL_CLE_BIT 4
`define UHL_SOC_LSB 16
`define UHL_CTRL_RST 5'h00
`define UHL_CMD_RST 4'h0
`define UHL_SOC_RST 2'h0
`define UHL_RESP_OKAY 2'h0
`define UHL_RESP_SLVERR 2'h2
`endif

/* src/uhl_pkg.sv */
// Types shared by the list control block
`default_nettype none
package uhl_pkg;
  // Frame phase of the list scheduler
  typedef enum logic [1:0] {UHL_WAIT_SOF, UHL_PERIODIC, UHL_NONPERIODIC} uhl_phase_t;
  // AXI4-Lite master to slave
  typedef struct packed {
    logic awvalid;
    logic [11:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [11:0] araddr;
    logic rready;
  } uhl_axil_req_t;
  // AXI4-Lite slave to master
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } uhl_axil_rsp_t;
  // Scheduler events, one-cycle pulses except cmdClear
  typedef struct packed {
    logic sof;
    logic eof;
    logic periodicDone;
    logic isoEdSeen;
    logic ctlCheck;
    logic npDecide;
    logic ctlServed;
    logic [3:0] cmdClear;
  } uhl_sched_in_t;
  // Answers to the scheduler
  typedef struct packed {
    logic ctlGrantValid;
    logic ctlGrant;
    logic periodicRun;
    logic periodicHalt;
    logic decideValid;
    logic serveControl;
    logic overrunSet;
    logic [1:0] socCount;
    logic [3:0] cmdBits;
  } uhl_sched_out_t;
  typedef struct packed {
    logic en;
  } uhl_latch_st_t;
  typedef struct packed {
    logic [2:0] count;
    logic decideValid;
    logic serveControl;
  } uhl_arb_st_t;
endpackage : uhl_pkg
`default_nettype wire

/* src/uhl_frame_latch.sv */
// Enable bit sampled once per frame at SOF
`default_nettype none
module uhl_frame_latch (
  input wire logic core_clk, // Clock
  input wire logic reset, // Sync reset, high
  input wire logic ce, // Clock enable
  input wire logic sof, // Frame start pulse
  input wire logic liveEn, // Software enable bit
  output logic frameEn // Enable for this frame
);
  import uhl_pkg::*;
  uhl_latch_st_t st_reg, st_next;
  // Take the live bit only at frame start
  always_comb begin
    st_next = st_reg;
    if (sof) begin
      st_next.en = liveEn;
    end
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end
  assign frameEn = st_reg.en;
  // Mid-frame changes never leak in
  frame_hold_a: assert property (@(posedge core_clk) disable iff (reset)
    (!sof) |=> frameEn == $past(frameEn)) else $error("frame enable moved inside a frame");
endmodule : uhl_frame_latch
`default_nettype wire

/* src/uhl_ratio_arbiter.sv */
// Control versus bulk choice by service ratio
`default_nettype none
module uhl_ratio_arbiter (
  input wire logic core_clk, // Clock
  input wire logic reset, // Sync reset, high
  input wire logic ce, // Clock enable
  input wire logic [1:0] ratio, // Service ratio code
  input wire logic ctlServed, // Nonempty control ED done
  input wire logic npDecide, // Decision request
  output logic decideValid, // Decision pulse
  output logic serveControl // 1 control, 0 bulk
);
  import uhl_pkg::*;
  uhl_arb_st_t st_reg, st_next;
  // Count survives frame edges; only a bulk turn clears it
  always_comb begin
    st_next = st_reg;
    st_next.decideValid = 1'b0;
    if (npDecide) begin
      st_next.decideValid = 1'b1;
      st_next.serveControl = (st_reg.count <= {1'b0, ratio});
      if (st_reg.count > {1'b0, ratio}) begin
        st_next.count = 3'h0;
      end
    end else if (ctlServed && st_reg.count != 3'h7) begin
      st_next.count = st_reg.count + 3'h1;
    end
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end
  assign decideValid = st_reg.decideValid;
  assign serveControl = st_reg.serveControl;
  ratio_pick_a: assert property (@(posedge core_clk) disable iff (reset)
    (ce && npDecide) |=> decideValid && serveControl == ($past(st_reg.count) <= {1'b0, $past(ratio)}))
    else $error("ratio decision wrong");
  count_keep_a: assert property (@(posedge core_clk) disable iff (reset)
    (!npDecide && !ctlServed) |=> st_reg.count == $past(st_reg.count)) else $error("served count lost");
  bulk_turn_c: cover property (@(posedge core_clk) disable iff (reset) decideValid && !serveControl);
endmodule : uhl_ratio_arbiter
`default_nettype wire

/* src/uhl_list_control.sv */
// List enables, command status and overrun count of the host list scheduler
//
// Local design decision: the AXI4-Lite slave port.
`include "uhl_params.svh"
`default_nettype none
module uhl_list_control (
  input wire logic core_clk, // Clock, 40 MHz
  input wire logic reset, // Sync reset, high
  input wire logic ce, // Clock enable
  input wire uhl_pkg::uhl_axil_req_t axiReq, // Bus requests
  output uhl_pkg::uhl_axil_rsp_t axiRsp, // Bus answers
  input wire uhl_pkg::uhl_sched_in_t schedIn, // Scheduler events
  output uhl_pkg::uhl_sched_out_t schedOut // Scheduler answers
);
  import uhl_pkg::*;

  // ------------------------------------------------
  // State
  // ------------------------------------------------
  typedef struct packed {
    logic [4:0] ctrl;
    logic [3:0] cmd;
    logic [1:0] soc;
    uhl_phase_t phase;
    logic periodicRun;
    logic periodicHalt;
    logic overrunSet;
    logic ctlGrantValid;
    logic ctlGrant;
    logic awHeld;
    logic [11:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    uhl_axil_rsp_t rsp;
  } uhl_top_st_t;

  uhl_top_st_t st_reg, st_next;
  logic fCle;
  logic fIe;
  logic fPle;
  logic wrFire;
  logic wrCtrl;
  logic wrCmd;
  logic [31:0] rdData;
  logic rdHit;
  logic [31:0] wrMask;
  logic [1:0] socInc;

  // ------------------------------------------------
  // Frame copies of the enables
  // ------------------------------------------------
  // Sampled at SOF so software edits never hit a frame in flight
  uhl_frame_latch u_cle (
    .core_clk(core_clk),
    .reset(reset),
    .ce(ce),
    .sof(schedIn.sof),
    .liveEn(st_reg.ctrl[`UHL_CLE_BIT]),
    .frameEn(fCle)
  );
  uhl_frame_latch u_ie (
    .core_clk(core_clk),
    .reset(reset),
    .ce(ce),
    .sof(schedIn.sof),
    .liveEn(st_reg.ctrl[`UHL_IE_BIT]),
    .frameEn(fIe)
  );
  uhl_frame_latch u_ple (
    .core_clk(core_clk),
    .reset(reset),
    .ce(ce),
    .sof(schedIn.sof),
    .liveEn(st_reg.ctrl[`UHL_PLE_BIT]),
    .frameEn(fPle)
  );

  // ------------------------------------------------
  // Service ratio
  // ------------------------------------------------
  uhl_ratio_arbiter u_arb (
    .core_clk(core_clk),
    .reset(reset),
    .ce(ce),
    .ratio(st_reg.ctrl[`UHL_RATIO_LSB +: 2]),
    .ctlServed(schedIn.ctlServed),
    .npDecide(schedIn.npDecide),
    .decideValid(schedOut.decideValid),
    .serveControl(schedOut.serveControl)
  );

  // ------------------------------------------------
  // Address decode and read mux
  // ------------------------------------------------
  // Byte lanes of the write strobe
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wrMask[8*i +: 8] = {8{st_reg.wStrb[i]}};
    end
  end

  assign wrFire = st_reg.awHeld && st_reg.wHeld && !st_reg.rsp.bvalid;
  assign wrCtrl = wrFire && st_reg.awAddr == `UHL_CTRL_OFS;
  assign wrCmd = wrFire && st_reg.awAddr == `UHL_CMD_OFS;

  // Reserved bits read as zero
  always_comb begin
    rdData = 32'h0000_0000;
    rdHit = 1'b1;
    if (axiReq.araddr == `UHL_CTRL_OFS) begin
      rdData[4:0] = st_reg.ctrl;
    end else if (axiReq.araddr == `UHL_CMD_OFS) begin
      rdData[3:0] = st_reg.cmd;
      rdData[`UHL_SOC_LSB +: 2] = st_reg.soc;
    end else begin
      rdHit = 1'b0;
    end
  end

  // Overrun adds one, wraps from three to zero
  assign socInc = (st_reg.phase == UHL_PERIODIC && schedIn.eof) ? 2'h1 : 2'h0;

  // ------------------------------------------------
  // Next state
  // ------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.periodicHalt = 1'b0;
    st_next.overrunSet = 1'b0;
    st_next.ctlGrantValid = 1'b0;

    // Write channel: address and data in either order
    if (axiReq.awvalid && st_reg.rsp.awready) begin
      st_next.awHeld = 1'b1;
      st_next.awAddr = axiReq.awaddr;
    end
    if (axiReq.wvalid && st_reg.rsp.wready) begin
      st_next.wHeld = 1'b1;
      st_next.wData = axiReq.wdata;
      st_next.wStrb = axiReq.wstrb;
    end
    if (wrFire) begin
      st_next.awHeld = 1'b0;
      st_next.wHeld = 1'b0;
      st_next.rsp.bvalid = 1'b1;
      st_next.rsp.bresp = (wrCtrl || wrCmd) ? `UHL_RESP_OKAY : `UHL_RESP_SLVERR;
    end
    if (st_reg.rsp.bvalid && axiReq.bready) begin
      st_next.rsp.bvalid = 1'b0;
    end
    st_next.rsp.awready = !st_next.awHeld && !st_next.rsp.bvalid;
    st_next.rsp.wready = !st_next.wHeld && !st_next.rsp.bvalid;

    // Read channel: data captured into the response flop
    if (axiReq.arvalid && st_reg.rsp.arready) begin
      st_next.rsp.rvalid = 1'b1;
      st_next.rsp.rdata = rdData;
      st_next.rsp.rresp = rdHit ? `UHL_RESP_OKAY : `UHL_RESP_SLVERR;
      st_next.rsp.arready = 1'b0;
    end else if (st_reg.rsp.rvalid && axiReq.rready) begin
      st_next.rsp.rvalid = 1'b0;
      st_next.rsp.arready = 1'b1;
    end
    // Read address ready rises by itself out of reset; no extra flop needed
    if (!st_reg.rsp.arready && !st_reg.rsp.rvalid) begin
      st_next.rsp.arready = 1'b1;
    end

    // Control register, plain read/write per byte lane
    if (wrCtrl) begin
      st_next.ctrl = (st_reg.ctrl & ~wrMask[4:0]) | (st_reg.wData[4:0] & wrMask[4:0]);
    end

    // Command bits: hardware clear loses to a software set
    st_next.cmd = st_reg.cmd & ~schedIn.cmdClear;
    if (wrCmd) begin
      st_next.cmd = st_next.cmd | (st_reg.wData[3:0] & wrMask[3:0]);
    end

    // Overrun count; written ones are set on top of the increment
    st_next.soc = st_reg.soc + socInc;
    if (wrCmd) begin
      st_next.soc = st_next.soc | (st_reg.wData[`UHL_SOC_LSB +: 2] & wrMask[`UHL_SOC_LSB +: 2]);
    end

    // Control list gate asked at each visit
    if (schedIn.ctlCheck) begin
      st_next.ctlGrantValid = 1'b1;
      st_next.ctlGrant = fCle;
    end

    // Frame phase sequencing
    unique case (st_reg.phase)
      UHL_WAIT_SOF: begin
      end
      UHL_PERIODIC: begin
        if (schedIn.eof) begin
          st_next.overrunSet = 1'b1;
          st_next.phase = UHL_WAIT_SOF;
        end else if (schedIn.periodicDone) begin
          st_next.phase = UHL_NONPERIODIC;
        end else if (schedIn.isoEdSeen && !fIe) begin
          st_next.periodicHalt = 1'b1;
          st_next.phase = UHL_NONPERIODIC;
        end
      end
      UHL_NONPERIODIC: begin
        if (schedIn.eof) begin
          st_next.phase = UHL_WAIT_SOF;
        end
      end
    endcase

    // A new frame starts the periodic list only if enabled
    if (schedIn.sof) begin
      st_next.phase = st_reg.ctrl[`UHL_PLE_BIT] ? UHL_PERIODIC : UHL_NONPERIODIC;
    end
    st_next.periodicRun = st_next.phase == UHL_PERIODIC;
  end

  // ------------------------------------------------
  // Registers
  // ------------------------------------------------
  // Ready flags come up one cycle after reset
  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_reg <= '0;
      st_reg.ctrl <= `UHL_CTRL_RST;
      st_reg.cmd <= `UHL_CMD_RST;
      st_reg.soc <= `UHL_SOC_RST;
      st_reg.phase <= UHL_WAIT_SOF;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  // ------------------------------------------------
  // Outputs
  // ------------------------------------------------
  // All taken straight from the state record flops
  assign axiRsp = st_reg.rsp;
  assign schedOut.ctlGrantValid = st_reg.ctlGrantValid;
  assign schedOut.ctlGrant = st_reg.ctlGrant;
  assign schedOut.periodicRun = st_reg.periodicRun;
  assign schedOut.periodicHalt = st_reg.periodicHalt;
  assign schedOut.overrunSet = st_reg.overrunSet;
  assign schedOut.socCount = st_reg.soc;
  assign schedOut.cmdBits = st_reg.cmd;

  // ------------------------------------------------
  // Checks
  // ------------------------------------------------
  // Grant answers each check with the frame copy of the enable
  ctl_grant_a: assert property (@(posedge core_clk) disable iff (reset)
    (ce && schedIn.ctlCheck) |=> schedOut.ctlGrantValid && schedOut.ctlGrant == $past(fCle))
    else $error("control grant does not follow frame enable");
  // A cleared enable shuts the control list from the next frame on
  ctl_shut_a: assert property (@(posedge core_clk) disable iff (reset)
    (ce && schedIn.sof && !st_reg.ctrl[`UHL_CLE_BIT]) |=> !fCle)
    else $error("control enable kept past sof after clear");
  // Grant level stands between two checks
  grant_hold_a: assert property (@(posedge core_clk) disable iff (reset)
    (ce && !schedIn.ctlCheck) |=> schedOut.ctlGrant == $past(schedOut.ctlGrant))
    else $error("control grant moved without a check");

  // Iso enable edits wait for the next frame
  iso_hold_a: assert property (@(posedge core_clk) disable iff (reset)
    (ce && !schedIn.sof && fIe != st_reg.ctrl[`UHL_IE_BIT]) |=> fIe == $past(fIe))
    else $error("iso enable acted within the frame");
  // Iso ED with iso off halts the periodic list
  iso_halt_a: assert property (@(posedge core_clk) disable iff (reset)
    (ce && st_reg.phase == UHL_PERIODIC && schedIn.isoEdSeen && !fIe && !schedIn.eof
    && !schedIn.periodicDone && !schedIn.sof) |=> schedOut.periodicHalt && !schedOut.periodicRun)
    else $error("periodic list not halted at iso ED");

  // Periodic list starts only when enabled at sof
  per_start_a: assert property (@(posedge core_clk) disable iff (reset)
    (ce && schedIn.sof) |=> schedOut.periodicRun == $past(st_reg.ctrl[`UHL_PLE_BIT]))
    else $error("periodic start ignores enable");
  // Periodic list never runs in a frame whose enable was clear
  per_gate_a: assert property (@(posedge core_clk) disable iff (reset)
    schedOut.periodicRun |-> fPle)
    else $error("periodic list ran while disabled");
  // Outside the periodic phase neither halt nor overrun may fire
  np_quiet_a: assert property (@(posedge core_clk) disable iff (reset)
    (ce && st_reg.phase != UHL_PERIODIC) |=> !schedOut.periodicHalt && !schedOut.overrunSet)
    else $error("halt or overrun outside periodic phase");

  // Overrun pulses the flag request and bumps the count
  overrun_count_a: assert property (@(posedge core_clk) disable iff (reset)
    (ce && st_reg.phase == UHL_PERIODIC && schedIn.eof && !schedIn.sof && !wrCmd)
    |=> schedOut.overrunSet && schedOut.socCount == 2'($past(st_reg.soc) + 2'h1))
    else $error("overrun not counted");
  // Count wraps from three to zero
  soc_wrap_a: assert property (@(posedge core_clk) disable iff (reset)
    (ce && st_reg.soc == 2'h3 && socInc == 2'h1 && !wrCmd) |=> st_reg.soc == 2'h0)
    else $error("overrun count did not wrap");
  // Count moves only on an overrun or a write
  soc_keep_a: assert property (@(posedge core_clk) disable iff (reset)
    (ce && socInc == 2'h0 && !wrCmd) |=> schedOut.socCount == $past(schedOut.socCount))
    else $error("overrun count moved on its own");

  // Reset clears enables, ratio and count
  reset_clear_a: assert property (@(posedge core_clk)
    reset |=> st_reg.soc == 2'h0 && st_reg.ctrl == 5'h00)
    else $error("reset left state behind");

  // Only the scheduler clear can drop a command bit
  cmd_sticky_a: assert property (@(posedge core_clk) disable iff (reset)
    (ce && schedIn.cmdClear == 4'h0) |=> (st_reg.cmd & $past(st_reg.cmd)) == $past(st_reg.cmd))
    else $error("command bit cleared by a write");
  // Every written one ends up set, even against a same-cycle clear
  cmd_set_a: assert property (@(posedge core_clk) disable iff (reset)
    (ce && wrCmd && st_reg.wStrb[0]) |=> (schedOut.cmdBits | ~$past(st_reg.wData[3:0])) == 4'hf)
    else $error("written command bit not set");
  // Command status reads back bits and count
  cmd_read_a: assert property (@(posedge core_clk) disable iff (reset)
    (ce && axiReq.arvalid && axiRsp.arready && axiReq.araddr == `UHL_CMD_OFS)
    |=> axiRsp.rvalid && axiRsp.rdata[3:0] == $past(st_reg.cmd)
    && axiRsp.rdata[`UHL_SOC_LSB +: 2] == $past(st_reg.soc))
    else $error("command status read wrong");

  // ------------------------------------------------
  // Cover points
  // ------------------------------------------------
  // Main scenarios the bench must reach
  overrun_c: cover property (@(posedge core_clk) disable iff (reset) schedOut.overrunSet);
  iso_halt_c: cover property (@(posedge core_clk) disable iff (reset) schedOut.periodicHalt);
  cmd_write_c: cover property (@(posedge core_clk) disable iff (reset) ce && wrCmd);
  ctl_grant_c: cover property (@(posedge core_clk) disable iff (reset) schedOut.ctlGrantValid && schedOut.ctlGrant);
endmodule : uhl_list_control
`default_nettype wire

/* tb/uhl_host_model.sv */
// Host driver model: AXI4-Lite master with blocking register tasks
`default_nettype none
module uhl_host_model (
  input wire logic core_clk, // Clock
  input wire uhl_pkg::uhl_axil_rsp_t axiRsp, // Slave answers
  output var uhl_pkg::uhl_axil_req_t axiReq // Master requests
);
  timeunit 1ns;
  timeprecision 1ps;
  import uhl_pkg::*;
  // Idle bus from time zero
  initial axiReq = '0;
  // Address and data offered together, each dropped at its own take
  task automatic write(input logic [11:0] addr, input logic [31:0] data, output logic [1:0] resp);
    logic awDone;
    logic wDone;
    awDone = 1'b0;
    wDone = 1'b0;
    @(posedge core_clk);
    axiReq.awvalid <= 1'b1;
    axiReq.awaddr <= addr;
    axiReq.wvalid <= 1'b1;
    axiReq.wdata <= data;
    axiReq.wstrb <= 4'hf;
    axiReq.bready <= 1'b1;
    while (!(awDone && wDone)) begin
      @(posedge core_clk);
      if (!awDone && axiRsp.awready === 1'b1) begin
        awDone = 1'b1;
        axiReq.awvalid <= 1'b0;
      end
      if (!wDone && axiRsp.wready === 1'b1) begin
        wDone = 1'b1;
        axiReq.wvalid <= 1'b0;
      end
    end
    // Response only counts at an edge where bvalid is seen high
    do @(posedge core_clk); while (axiRsp.bvalid !== 1'b1);
    resp = axiRsp.bresp;
    axiReq.bready <= 1'b0;
  endtask : write
  // Read with rready held until rvalid is seen
  task automatic read(input logic [11:0] addr, output logic [31:0] data, output logic [1:0] resp);
    @(posedge core_clk);
    axiReq.arvalid <= 1'b1;
    axiReq.araddr <= addr;
    axiReq.rready <= 1'b1;
    do @(posedge core_clk); while (axiRsp.arready !== 1'b1);
    axiReq.arvalid <= 1'b0;
    do @(posedge core_clk); while (axiRsp.rvalid !== 1'b1);
    data = axiRsp.rdata;
    resp = axiRsp.rresp;
    axiReq.rready <= 1'b0;
  endtask : read
endmodule : uhl_host_model
`default_nettype wire

/* tb/tb_usb_host_list_control.sv */
// Self-checking bench of the list control block
`include "uhl_params.svh"
`default_nettype none
module tb_usb_host_list_control;
  timeunit 1ns;
  timeprecision 1ps;
  import uhl_pkg::*;
  // ----------------------------------------
  // Scheduler event codes
  // ----------------------------------------
  localparam logic [10:0] EV_SOF = 11'h400;
  localparam logic [10:0] EV_EOF = 11'h200;
  localparam logic [10:0] EV_DONE = 11'h100;
  localparam logic [10:0] EV_ISO = 11'h080;
  localparam logic [10:0] EV_CHK = 11'h040;
  localparam logic [10:0] EV_DEC = 11'h020;
  localparam logic [10:0] EV_SRV = 11'h010;
  localparam logic [11:0] CTRL = `UHL_CTRL_OFS;
  localparam logic [11:0] CMD = `UHL_CMD_OFS;
  logic core_clk;
  logic reset;
  logic ce;
  uhl_axil_req_t axiReq;
  uhl_axil_rsp_t axiRsp;
  uhl_sched_in_t schedIn;
  uhl_sched_out_t schedOut;
  int n_errors;
  int n_tests;
  logic [31:0] rd;
  logic [1:0] resp;
  logic [1:0] soc;
  // Clock enable driven by the bench; one scenario freezes the block
  uhl_list_control uhl_list_control_inst (
    .core_clk(core_clk),
    .reset(reset),
    .ce(ce),
    .axiReq(axiReq),
    .axiRsp(axiRsp),
    .schedIn(schedIn),
    .schedOut(schedOut)
  );
  uhl_host_model uhl_host_model_inst (
    .core_clk(core_clk),
    .axiRsp(axiRsp),
    .axiReq(axiReq)
  );
  // ----------------------------------------
  // Clock, helpers and verdict
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check
  // One-cycle event; returns just after the edge that answers it
  task automatic ev(input logic [10:0] p);
    @(posedge core_clk);
    schedIn <= uhl_sched_in_t'(p);
    @(posedge core_clk);
    schedIn <= '0;
    #1;
  endtask : ev
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    uhl_host_model_inst.write(a, d, resp);
  endtask : wr
  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict
  // Hang guard, well beyond the few hundred cycles of the tests
  initial begin
    repeat (5000) @(posedge core_clk);
    n_errors++;
    $display("unexpected watchdog: expected done, seen hang");
    print_verdict();
  end
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    reset = 1'b1;
    ce = 1'b1;
    schedIn = '0;
    n_errors = 0;
    n_tests = 0;
    soc = 2'h0;
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    // Reset state of both registers
    uhl_host_model_inst.read(CTRL, rd, resp);
    check("control reset", rd, 32'h0);
    uhl_host_model_inst.read(CMD, rd, resp);
    check("command reset", rd, 32'h0);
    // Unmapped place refused, nothing read back
    wr(12'h00c, 32'hffffffff);
    check("unmapped bresp", resp, `UHL_RESP_SLVERR);
    uhl_host_model_inst.read(12'h00c, rd, resp);
    check("unmapped rresp", resp, `UHL_RESP_SLVERR);
    check("unmapped rdata", rd, 32'h0);
    // Reserved bits always written as zero
    wr(CTRL, 32'h0000001f);
    check("control bresp", resp, `UHL_RESP_OKAY);
    uhl_host_model_inst.read(CTRL, rd, resp);
    check("control readback", rd, 32'h1f);
    wr(CTRL, 32'h0);
    // Write-to-set: a later command never disturbs an earlier one
    wr(CMD, 32'h1);
    wr(CMD, 32'h2);
    uhl_host_model_inst.read(CMD, rd, resp);
    check("command set", rd, 32'h3);
    check("command bits", schedOut.cmdBits, 4'h3);
    ev(11'h001);
    check("command cleared", schedOut.cmdBits, 4'h2);
    wr(CMD, 32'h0);
    uhl_host_model_inst.read(CMD, rd, resp);
    check("zero write keeps", rd, 32'h2);
    // Control enable seen only from the next frame
    wr(CTRL, 32'h10);
    ev(EV_CHK);
    check("grant valid", schedOut.ctlGrantValid, 1'b1);
    check("grant before sof", schedOut.ctlGrant, 1'b0);
    ev(EV_SOF);
    ev(EV_CHK);
    check("grant after sof", schedOut.ctlGrant, 1'b1);
    wr(CTRL, 32'h0);
    ev(EV_CHK);
    check("grant held in frame", schedOut.ctlGrant, 1'b1);
    ev(EV_SOF);
    ev(EV_CHK);
    check("grant dropped", schedOut.ctlGrant, 1'b0);
    // No pointer lives here, so re-enabling needs no pointer update first
    // Every ratio code, with a frame boundary inside each run
    for (int r = 0; r < 4; r++) begin
      wr(CTRL, 32'(r));
      for (int k = 0; k <= r; k++) begin
        ev(EV_SRV);
        if (k == 0) ev(EV_SOF);
        ev(EV_DEC);
        check("decide valid", schedOut.decideValid, 1'b1);
        check("serve control", schedOut.serveControl, 32'(k < r));
      end
    end
    // Periodic enable latched at sof
    wr(CTRL, 32'h0);
    ev(EV_SOF);
    check("periodic off", schedOut.periodicRun, 1'b0);
    wr(CTRL, 32'h4);
    check("periodic not yet", schedOut.periodicRun, 1'b0);
    ev(EV_SOF);
    check("periodic on", schedOut.periodicRun, 1'b1);
    // Iso enable set mid-frame must not help this frame
    wr(CTRL, 32'hc);
    ev(EV_ISO);
    check("iso halt", schedOut.periodicHalt, 1'b1);
    ev(EV_EOF);
    check("eof after halt", schedOut.overrunSet, 1'b0);
    ev(EV_SOF);
    ev(EV_ISO);
    check("iso continues", schedOut.periodicHalt, 1'b0);
    // Overruns counted every time, wrapping past three
    for (int i = 0; i < 5; i++) begin
      if (i > 0) ev(EV_SOF);
      ev(EV_EOF);
      soc = soc + 2'h1;
      check("overrun pulse", schedOut.overrunSet, 1'b1);
      check("overrun count", schedOut.socCount, soc);
    end
    // Finished periodic list is no overrun
    ev(EV_SOF);
    ev(EV_DONE);
    ev(EV_EOF);
    check("done no overrun", schedOut.overrunSet, 1'b0);
    uhl_host_model_inst.read(CMD, rd, resp);
    check("count readback", rd, {14'h0, soc, 16'h2});
    // Clock enable low: a frame start must not move anything
    @(posedge core_clk);
    ce <= 1'b0;
    ev(EV_SOF);
    check("frozen phase", schedOut.periodicRun, 1'b0);
    @(posedge core_clk);
    ce <= 1'b1;
    ev(EV_SOF);
    check("thawed phase", schedOut.periodicRun, 1'b1);
    // Mid-run reset clears the enables, the ratio and the count
    @(posedge core_clk);
    reset <= 1'b1;
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    uhl_host_model_inst.read(CTRL, rd, resp);
    check("control after reset", rd, 32'h0);
    uhl_host_model_inst.read(CMD, rd, resp);
    check("count after reset", rd, 32'h0);
    check("run after reset", schedOut.periodicRun, 1'b0);
    print_verdict();
  end
endmodule : tb_usb_host_list_control
`default_nettype wire
